// *** logic/aacb_pkg.sv ***
// package for the and/carry-branch execution block
// assumes a 16-bit instruction word, 8-bit data path, byte-addressed program counter
package aacb_pkg;
  // ==========================================================
  // encodings
  localparam logic [5:0]  AACB_AND_OPC      = 6'h05;   // upper bits 0001 01
  localparam logic [7:0]  AACB_BRC_OPC      = 8'he2;   // upper bits 1110 0010
  localparam int          AACB_DSEL_BIT     = 9;
  localparam int          AACB_ABIT_BIT     = 8;
  // ==========================================================
  // addressing
  localparam logic [7:0]  AACB_IDX_LIMIT    = 8'h5f;   // indexed offsets at or below 95
  localparam logic [7:0]  AACB_ACC_SPLIT    = 8'h80;   // low half of access bank is bank 0
  localparam logic [3:0]  AACB_ACC_HI_BANK  = 4'hf;
  localparam logic [20:0] AACB_PC_STEP      = 21'h000002;
  // ==========================================================
  // reset values
  localparam logic [7:0]  AACB_W_RST        = 8'h00;
  localparam logic [20:0] AACB_PC_RST       = 21'h000000;
  localparam logic [4:0]  AACB_STAT_RST     = 5'h00;
  localparam int          AACB_FLAG_C       = 0;
  localparam int          AACB_FLAG_Z       = 2;
  localparam int          AACB_FLAG_N       = 4;

  typedef enum logic [1:0] {
    AACB_RUN  = 2'b01,
    AACB_IDLE = 2'b10
  } aacb_state_type;
endpackage : aacb_pkg

// *** logic/aacb_addr_gen.sv ***
// data-memory address former for the file operand
// assumes bank register and index pointer are stable in the execute cycle
`timescale 1ns/1ps
module aacb_addr_gen
(
  input  wire logic [15:0] instr,
  input  wire logic [3:0]  bank_selection_reg,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_ptr,
  output logic      [11:0] data_addr,
  output logic             indexed
);
  import aacb_pkg::*;

  // ==========================================================
  // address decode
  wire logic [7:0] file_f    = instr[7:0];
  wire logic       acc_clear = ~instr[AACB_ABIT_BIT];
  assign indexed   = acc_clear & ext_set_en & (file_f <= AACB_IDX_LIMIT);
  wire logic [11:0] acc_addr = (file_f < AACB_ACC_SPLIT) ? {4'h0, file_f}
                                                         : {AACB_ACC_HI_BANK, file_f};
  wire logic [11:0] bank_addr = {bank_selection_reg, file_f};
  wire logic [11:0] idx_addr  = index_ptr + {4'h0, file_f};
  assign data_addr = indexed ? idx_addr : (acc_clear ? acc_addr : bank_addr);
endmodule : aacb_addr_gen

// *** logic/aacb_exec.sv ***
// execution of the and-with-file and branch-on-carry instructions
// assumes one instruction presented per cycle with instr_valid; data memory read is
// combinational on file_rdata for the addressed word
// acc_load writes the accumulator from the rest of the core between instructions
//
// Summary of operation
// - opcode 0001 01 ands the working accumulator with the file byte at the low 8 bits.
// - with destination bit clear the result goes to the working accumulator only.
// - with destination bit set the result is written back to the file register.
// - with access bit clear the address lies in the fixed access bank.
// - with access bit set the bank register forms the upper address bits.
// - access clear plus extended set makes addresses up to 95 indexed offsets.
// - the carry branch is taken only when carry is one, otherwise execution falls through.
// - a taken branch loads pc with the instruction address plus two plus twice the offset.
// - a taken branch costs two cycles with an idle second one; untaken costs one.
`timescale 1ns/1ps
module aacb_exec
#(
  parameter int PC_W = 21
)(
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire logic            clk_en,
  input  wire logic            instr_valid,
  input  wire logic [15:0]     instr,
  input  wire logic [3:0]      bank_selection_reg,
  input  wire logic            ext_set_en,
  input  wire logic [11:0]     index_ptr,
  input  wire logic [7:0]      file_rdata,
  input  wire logic            carry_in,
  input  wire logic            acc_load,
  input  wire logic [7:0]      acc_load_data,
  output logic      [11:0]     file_addr,
  output logic      [7:0]      file_wdata,
  output logic                 file_we,
  output logic      [7:0]      working_accumulator,
  output logic      [4:0]      status_flags,
  output logic      [PC_W-1:0] pc,
  output logic                 flush_prefetch,
  output logic                 busy
);
  import aacb_pkg::*;

  aacb_state_type  state_q, state_d;
  logic [11:0]     addr_q;
  logic [7:0]      wdata_q, w_q;
  logic            we_q, flush_q;
  // busy gets its own flop so the pin never comes from a compare
  logic            busy_q;
  logic [4:0]      stat_q;
  logic [PC_W-1:0] pc_q;
  wire  logic [11:0] addr_c;
  wire  logic        idx_c;

  // ==========================================================
  // operand addressing
  aacb_addr_gen u_addr (
    .instr              (instr),
    .bank_selection_reg (bank_selection_reg),
    .ext_set_en         (ext_set_en),
    .index_ptr          (index_ptr),
    .data_addr          (addr_c),
    .indexed            (idx_c)
  );

  // ==========================================================
  // decode; the branch tests carry_in directly, and the and copies carry_in into status as well
  wire logic       run     = clk_en & instr_valid & (state_q == AACB_RUN);
  wire logic       is_and  = run & (instr[15:10] == AACB_AND_OPC);
  wire logic       is_brc  = run & (instr[15:8] == AACB_BRC_OPC);
  wire logic [7:0] and_res = w_q & file_rdata;
  wire logic       dsel    = instr[AACB_DSEL_BIT];
  wire logic       take    = is_brc & carry_in;
  // pc step shared by the taken and the fall-through paths
  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] base,
                                              input logic [PC_W-1:0] disp);
    pc_add = base + PC_W'(AACB_PC_STEP) + disp;
  endfunction : pc_add

  // target pc plus two plus twice offset
  wire logic [PC_W-1:0] off2   = PC_W'({{(PC_W-9){instr[7]}}, instr[7:0], 1'b0});
  wire logic [PC_W-1:0] target = pc_add(pc_q, off2);
  wire logic [PC_W-1:0] seq    = pc_add(pc_q, {PC_W{1'b0}});

  // idle cycle after a taken branch
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      AACB_RUN:  if (take) state_d = AACB_IDLE;
      AACB_IDLE: if (clk_en) state_d = AACB_RUN;
      default:   state_d = AACB_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= AACB_RUN;
      busy_q  <= 1'b0;
      flush_q <= 1'b0;
      pc_q    <= PC_W'(AACB_PC_RST);
    end else if (clk_en) begin
      state_q <= state_d;
      // busy follows the next state so it rises with the idle slot itself
      busy_q  <= (state_d == AACB_IDLE);
      flush_q <= take;
      if (take) pc_q <= target;
      else if (run) pc_q <= seq;
    end
  end

  // ==========================================================
  // and result steering; write port only strobes for one cycle
  // limitation: a low clk_en holds a raised file_we as well, so the file
  // memory has to honour the same enable or it would write twice
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_q     <= AACB_W_RST;
      we_q    <= 1'b0;
      addr_q  <= 12'h000;
      wdata_q <= 8'h00;
      stat_q  <= AACB_STAT_RST;
    end else if (clk_en) begin
      we_q    <= is_and & dsel;
      addr_q  <= addr_c;
      wdata_q <= and_res;
      if (is_and && !dsel) begin
        w_q <= and_res;
      end else if (acc_load) begin
        // an outside load gives way to an and aimed at the accumulator
        w_q <= acc_load_data;
      end
      if (is_brc || is_and) stat_q[AACB_FLAG_C] <= carry_in;
      if (is_and) begin
        stat_q[AACB_FLAG_N] <= and_res[7];
        stat_q[AACB_FLAG_Z] <= (and_res == 8'h00);
      end
    end
  end

  // outputs are plain copies of flops; nothing combinational reaches a pin
  assign file_addr           = addr_q;
  assign file_wdata          = wdata_q;
  assign file_we             = we_q;
  assign working_accumulator = w_q;
  assign status_flags        = stat_q;
  assign pc                  = pc_q;
  assign flush_prefetch      = flush_q;
  assign busy                = busy_q;

  // ==========================================================
  // checks
  // every property samples on core_clk and stays quiet while reset_n is low
  AST_AND_W: assert property (@(posedge core_clk) disable iff (!reset_n)
    (is_and && !dsel) |=> (w_q == $past(and_res)) && !we_q)
    else $error("and to accumulator wrong");
  AST_AND_F: assert property (@(posedge core_clk) disable iff (!reset_n)
    (is_and && dsel) |=> we_q && (wdata_q == $past(and_res)) && $stable(w_q))
    else $error("and write back wrong");
  AST_FLAGS: assert property (@(posedge core_clk) disable iff (!reset_n)
    is_and |=> stat_q[AACB_FLAG_Z] == (wdata_q == 8'h00) && stat_q[AACB_FLAG_N] == wdata_q[7])
    else $error("n or z flag wrong");
  AST_IDX: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!instr[AACB_ABIT_BIT] && ext_set_en && instr[7:0] <= AACB_IDX_LIMIT) |->
      idx_c && addr_c == index_ptr + {4'h0, instr[7:0]})
    else $error("indexed mode missed");
  AST_BANK: assert property (@(posedge core_clk) disable iff (!reset_n)
    (instr[AACB_ABIT_BIT]) |-> addr_c == {bank_selection_reg, instr[7:0]})
    else $error("banked address wrong");
  AST_ACC: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!instr[AACB_ABIT_BIT] && !idx_c) |-> addr_c[7:0] == instr[7:0] &&
      addr_c[11:8] == (instr[7] ? AACB_ACC_HI_BANK : 4'h0))
    else $error("access bank address wrong");
  // a taken branch has two steps: the branch edge, then the idle slot
  sequence s_taken;
    is_brc && carry_in;
  endsequence
  sequence s_idle_slot;
    busy && flush_prefetch;
  endsequence
  // target worked out from the last pc and offset, not from the target net
  AST_TAKEN: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_taken |=> pc_q == $past(pc_q) + PC_W'(AACB_PC_STEP) +
      PC_W'({{(PC_W-9){$past(instr[7])}}, $past(instr[7:0]), 1'b0}))
    else $error("branch target wrong");
  AST_IDLE: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_taken |=> s_idle_slot)
    else $error("taken branch missed idle");
  // the idle slot discards whatever sits on instr and then hands back
  AST_IDLE_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (busy && clk_en) |=> !busy && !flush_prefetch && !file_we && $stable(pc))
    else $error("idle slot not empty");
  AST_NOTAKE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (is_brc && !carry_in) |=> !busy && pc_q == $past(pc_q) + PC_W'(AACB_PC_STEP))
    else $error("untaken branch not sequential");
  AST_DEC: assert property (@(posedge core_clk) disable iff (!reset_n)
    (run && instr[15:8] == 8'he2) |-> is_brc && !is_and)
    else $error("branch decode wrong");
  AST_OPC: assert property (@(posedge core_clk) disable iff (!reset_n)
    (run && instr[15:10] == 6'h05) |-> is_and)
    else $error("and decode wrong");
  // an outside load only lands when no and result claims the accumulator
  AST_LOAD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && acc_load && !(is_and && !dsel)) |=>
      working_accumulator == $past(acc_load_data))
    else $error("accumulator load lost");
  AST_W_KEEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && !acc_load && !(is_and && !dsel)) |=> $stable(working_accumulator))
    else $error("accumulator moved");
  // refused slots leave the program counter alone
  AST_PC_KEEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    !run |=> $stable(pc))
    else $error("pc moved without an instruction");
  // a low enable holds every output where it stands, the write strobe included
  AST_FREEZE: assert property (@(posedge core_clk) disable iff (!reset_n)
    !clk_en |=> $stable(pc) && $stable(working_accumulator) && $stable(status_flags) &&
      $stable(busy) && $stable(file_we))
    else $error("state moved with enable low");
endmodule : aacb_exec

// *** tb/aacb_testbench.sv ***
// self-checking bench for the and/carry-branch execution block
// assumes aacb_pkg and aacb_exec are compiled ahead of this file
`timescale 1ns/1ps
module testbench;
  import aacb_pkg::*;
  logic        core_clk, reset_n, clk_en, instr_valid, ext_set_en, carry_in, acc_load;
  logic [7:0]  acc_load_data;
  logic [15:0] instr;
  logic [3:0]  bank_selection_reg;
  logic [11:0] index_ptr, file_addr;
  logic [7:0]  file_rdata, file_wdata, working_accumulator;
  logic [4:0]  status_flags;
  logic [20:0] pc, exp_pc;
  logic        file_we, flush_prefetch, busy;
  int          errors, n_checks;
  aacb_exec #(.PC_W(21)) dut (.core_clk, .reset_n, .clk_en, .instr_valid, .instr,
    .bank_selection_reg, .ext_set_en, .index_ptr, .file_rdata, .carry_in, .acc_load,
    .acc_load_data, .file_addr,
    .file_wdata, .file_we, .working_accumulator, .status_flags, .pc, .flush_prefetch, .busy);
  // ==========================================================
  // clock and shared helpers
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task chk(input logic [20:0] got, input logic [20:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // inputs change only just after a rising edge, by non-blocking assignment
  task step(input logic [15:0] i, input logic v, input logic e);
    @(posedge core_clk);
    instr <= i;
    instr_valid <= v;
    clk_en <= e;
  endtask : step
  // loads the accumulator with w, then offers one and against file byte r
  task do_and(input logic d, input logic a, input logic ext, input logic [7:0] f,
              input logic [11:0] ea, input logic [7:0] w, input logic [7:0] r);
    logic [7:0] res;
    res = w & r;
    step(16'h0000, 1'b0, 1'b1);
    acc_load <= 1'b1;
    acc_load_data <= w;
    step({AACB_AND_OPC, d, a, f}, 1'b1, 1'b1);
    acc_load <= 1'b0;
    ext_set_en <= ext;
    file_rdata <= r;
    step(16'h0000, 1'b0, 1'b1);
    #1;
    exp_pc = exp_pc + 21'h2;
    chk(pc, exp_pc, "and pc");
    chk(file_we, d, "write strobe");
    chk(working_accumulator, d ? w : res, "accumulator");
    if (d) chk(file_wdata, res, "write data");
    chk(file_addr, ea, "file address");
    chk(status_flags, {res[7], 1'b0, res == 8'h00, 1'b0, carry_in}, "flags");
  endtask : do_and
  // other opcodes only step the pc and never write; a low enable moves nothing
  task do_ignored(input logic [15:0] i, input logic e);
    step(i, 1'b1, e);
    step(16'h0000, 1'b0, 1'b1);
    #1;
    if (e) exp_pc = exp_pc + 21'h2;
    chk(pc, exp_pc, "ignored pc");
    chk(file_we, 21'h0, "ignored strobe");
  endtask : do_ignored
  // the and offered right behind the branch runs only if no idle cycle follows
  task do_br(input logic c, input logic [7:0] n);
    step({AACB_BRC_OPC, n}, 1'b1, 1'b1);
    carry_in <= c;
    step({AACB_AND_OPC, 2'b11, 8'h01}, 1'b1, 1'b1);
    #1;
    exp_pc = exp_pc + 21'h2 + (c ? {{12{n[7]}}, n, 1'b0} : 21'h0);
    chk(pc, exp_pc, "branch pc");
    chk({busy, flush_prefetch}, {c, c}, "idle cycle");
    step(16'h0000, 1'b0, 1'b1);
    #1;
    if (!c) exp_pc = exp_pc + 21'h2;
    chk(pc, exp_pc, "after branch");
    chk({busy, flush_prefetch, file_we}, {2'b00, !c}, "second cycle");
  endtask : do_br
  // ==========================================================
  // scenarios
  task t_banked;
    @(posedge core_clk);
    bank_selection_reg <= 4'h3;
    do_and(1'b1, 1'b1, 1'b0, 8'ha5, 12'h3a5, 8'hf0, 8'h9c);
    do_and(1'b0, 1'b1, 1'b0, 8'h11, 12'h311, 8'h0f, 8'hf0);
    do_and(1'b1, 1'b1, 1'b1, 8'h10, 12'h310, 8'h17, 8'hc2);
    $display("banked and done");
  endtask : t_banked
  task t_access;
    do_and(1'b1, 1'b0, 1'b0, 8'h20, 12'h020, 8'hff, 8'h81);
    do_and(1'b1, 1'b0, 1'b0, 8'h90, 12'hf90, 8'h3c, 8'h3c);
    do_and(1'b1, 1'b0, 1'b1, 8'h5f, 12'h45f, 8'h55, 8'haa);
    do_and(1'b1, 1'b0, 1'b1, 8'h60, 12'h060, 8'hc3, 8'h7e);
    $display("access bank done");
  endtask : t_access
  task t_branch;
    do_br(1'b0, 8'h7f);
    do_br(1'b1, 8'h7f);
    do_br(1'b1, 8'h80);
    do_br(1'b1, 8'h00);
    $display("carry branch done");
  endtask : t_branch
  task t_refused;
    do_ignored({AACB_AND_OPC, 2'b11, 8'h40}, 1'b0);
    do_ignored({8'he3, 8'h05}, 1'b1);
    do_ignored({6'h06, 2'b11, 8'h40}, 1'b1);
    $display("refused requests done");
  endtask : t_refused
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {reset_n, clk_en, instr_valid, ext_set_en, carry_in, acc_load} = 6'h00;
    acc_load_data = 8'h00;
    instr = 16'h0000;
    bank_selection_reg = 4'h0;
    index_ptr = 12'h400;
    file_rdata = 8'h3c;
    exp_pc = 21'h0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    clk_en <= 1'b1;
    #1;
    chk(pc, 21'h0, "reset pc");
    chk({file_addr, file_wdata, file_we}, 21'h0, "reset write port");
    chk({working_accumulator, status_flags, busy, flush_prefetch}, 21'h0, "reset");
    t_banked();
    t_access();
    t_branch();
    t_refused();
    tally_and_finish();
  end
  initial begin
    repeat (400) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
endmodule : testbench
